// *** rtl/lmk_cfg.svh ***
`ifndef LMK_CFG_SVH
`define LMK_CFG_SVH

// ********************************************************************
// Clock rates and scan timing
// ********************************************************************
`define LMK_PCLK_KHZ 25000
`define LMK_OSC_KHZ 500
`define LMK_OSC_TICK_CYCLES (`LMK_PCLK_KHZ / `LMK_OSC_KHZ)
`define LMK_TICK_LAST 6'((`LMK_OSC_TICK_CYCLES) - 1)
`define LMK_STEP_LAST 4'hF
`define LMK_KEY_SOURCES 10
`define LMK_MIN_DIGITS 5'h04

// ********************************************************************
// Storage sizes
// ********************************************************************
`define LMK_MEM_BYTES 14
`define LMK_KEY_BITS 40
`define LMK_KEY_BITS_W 6'h28
`define LMK_ADDR_LAST 4'hD
`define LMK_ADDR_TOP 4'hF

// ********************************************************************
// Command classes and fields
// ********************************************************************
`define LMK_CMD_MODE 2'h0
`define LMK_CMD_DATA 2'h1
`define LMK_CMD_CTRL 2'h2
`define LMK_CMD_ADDR 2'h3
`define LMK_DS_WRITE 2'h0
`define LMK_DS_READ 2'h2
`define LMK_DS_FIXED_BIT 2
`define LMK_DS_TEST_BIT 3
`define LMK_DC_ON_BIT 3
`define LMK_KEY_ODD_BASE 0
`define LMK_KEY_EVEN_BASE 3

// ********************************************************************
// Power-on values
// ********************************************************************
`define LMK_MODE_RESET 2'h3
`define LMK_DIM_RESET 3'h0
`define LMK_DSET_RESET 4'h0
`define LMK_ADDR_RESET 4'h0
`define LMK_SCAN_EN_RESET 1'h1
`define LMK_SHARED_RESET 3'h7
`define LMK_DIG_N_RESET 4'hF

// ********************************************************************
// Bus register map and status fields
// ********************************************************************
`define LMK_REG_CTRL 8'h00
`define LMK_REG_STATUS 8'h04
`define LMK_REG_KEYS0 8'h08
`define LMK_REG_KEYS1 8'h0C
`define LMK_CTRL_SCAN_BIT 0
`define LMK_ST_MODE_POS 0
`define LMK_ST_ON_POS 2
`define LMK_ST_DIM_POS 3
`define LMK_ST_DSET_POS 6
`define LMK_ST_ADDR_POS 10
`define LMK_ST_READ_POS 14

`endif

// *** rtl/lmk_pkg.sv ***
`default_nettype none
`include "lmk_cfg.svh"

package lmk_pkg;

  typedef enum logic [1:0] {
    LNK_CMD,
    LNK_WRITE,
    LNK_READ
  } lmk_link_state_type;

  typedef struct packed {
    logic [9:0] seg_src;
    logic [2:0] shared;
    logic [3:0] dig_n;
  } lmk_drive_type;

  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic stb_s1;
    logic stb_s2;
    logic din_s1;
    logic din_s2;
    logic [1:0] key_s1;
    logic [1:0] key_s2;
    lmk_link_state_type lnk;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [5:0] rd_ptr;
    logic dio_oe;
    logic [1:0] mode;
    logic disp_on;
    logic [2:0] dim;
    logic [3:0] dset;
    logic [3:0] addr;
    logic [`LMK_MEM_BYTES-1:0][7:0] mem;
    logic [`LMK_KEY_BITS-1:0] keys;
    logic [`LMK_KEY_BITS-1:0] key_tmp;
    logic [5:0] tick;
    logic [3:0] step;
    logic [4:0] phase;
    lmk_drive_type drv;
    logic scan_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lmk_state_type;

endpackage

`default_nettype wire

// *** rtl/lmk_top.sv ***
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "lmk_cfg.svh"
`default_nettype none

module lmk_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shift_clock,
  input wire logic frame_select_strobe,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  input wire logic [1:0] key_return_inputs,
  output logic [9:0] segment_key_source_outputs,
  output logic [2:0] shared_segment_digit_outputs,
  output logic [3:0] digit_select_outputs_n
);
  import lmk_pkg::*;

  lmk_state_type st_ff;
  lmk_state_type nxt_st;

  // ******************************************************************
  // Decoding helpers
  // ******************************************************************
  function automatic logic [4:0] dim_width(input logic [2:0] code);
    logic [4:0] w;
    w = 5'h01;
    unique case (code)
      3'h0: w = 5'h01;
      3'h1: w = 5'h02;
      3'h2: w = 5'h04;
      3'h3: w = 5'h0A;
      3'h4: w = 5'h0B;
      3'h5: w = 5'h0C;
      3'h6: w = 5'h0D;
      3'h7: w = 5'h0E;
    endcase
    return w;
  endfunction

  // Segments 1..10 then 12,13,14 (segment 11 does not exist)
  function automatic logic [12:0] seg_map(input logic [7:0] lo,
                                          input logic [7:0] hi);
    return {hi[5], hi[4], hi[3], hi[1], hi[0], lo};
  endfunction

  function automatic logic [5:0] key_pos(input logic [3:0] src,
                                         input logic ret);
    logic [5:0] base;
    base = src[0] ? 6'(`LMK_KEY_EVEN_BASE) : 6'(`LMK_KEY_ODD_BASE);
    return 6'({src[3:1], 3'h0}) + base + 6'(ret);
  endfunction

  // Shared pin p serves as grid 7-p, i.e. digit index 6-p
  function automatic logic [4:0] shared_digit(input int p);
    return 5'(6 - p);
  endfunction

  // Each digit owns an even/odd byte pair of display memory
  function automatic logic [3:0] mem_index(input logic [4:0] phase,
                                           input logic odd);
    return {phase[2:0], odd};
  endfunction

  function automatic logic [4:0] digit_count(input logic [1:0] mode);
    return `LMK_MIN_DIGITS + 5'(mode);
  endfunction

  // Lit while the slot's step is below the selected width
  function automatic logic pwm_lit(input logic [3:0] step,
                                   input logic [2:0] code);
    return {1'b0, step} < dim_width(code);
  endfunction

  // Past the last key byte the line is left released, reading as ones
  function automatic logic key_out_bit(input logic [39:0] keys,
                                       input logic [5:0] ptr);
    logic b;
    b = 1'b1;
    if (ptr < `LMK_KEY_BITS_W) begin
      b = keys[ptr];
    end
    return b;
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == `LMK_REG_CTRL) || (a == `LMK_REG_STATUS) ||
           (a == `LMK_REG_KEYS0) || (a == `LMK_REG_KEYS1);
  endfunction

  function automatic logic [31:0] reg_read(input lmk_state_type s,
                                           input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    if (a == `LMK_REG_CTRL) begin
      d[`LMK_CTRL_SCAN_BIT] = s.scan_en;
    end else if (a == `LMK_REG_STATUS) begin
      d = (32'(s.mode) << `LMK_ST_MODE_POS) |
          (32'(s.disp_on) << `LMK_ST_ON_POS) |
          (32'(s.dim) << `LMK_ST_DIM_POS) |
          (32'(s.dset) << `LMK_ST_DSET_POS) |
          (32'(s.addr) << `LMK_ST_ADDR_POS) |
          (32'(s.lnk == LNK_READ) << `LMK_ST_READ_POS);
    end else if (a == `LMK_REG_KEYS0) begin
      d = s.keys[31:0];
    end else if (a == `LMK_REG_KEYS1) begin
      d = {24'h0, s.keys[39:32]};
    end
    return d;
  endfunction

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    logic rise;
    logic fall;
    logic [7:0] byte_in;
    logic [4:0] ndig;
    logic [4:0] last;
    logic [4:0] src;
    logic [39:0] tmp;
    logic [12:0] segs;
    logic [2:0] grid_used;
    logic setup;
    logic access;

    rise = 1'b0;
    fall = 1'b0;
    byte_in = 8'h00;
    ndig = 5'h00;
    last = 5'h00;
    src = 5'h00;
    tmp = 40'h0;
    segs = 13'h0;
    grid_used = 3'h0;
    setup = 1'b0;
    access = 1'b0;

    nxt_st = st_ff;

    // Pin synchronisers
    // Third shift clock stage only feeds the edge detector
    nxt_st.sclk_s1 = shift_clock;
    nxt_st.sclk_s2 = st_ff.sclk_s1;
    nxt_st.sclk_d = st_ff.sclk_s2;
    nxt_st.stb_s1 = frame_select_strobe;
    nxt_st.stb_s2 = st_ff.stb_s1;
    nxt_st.din_s1 = serial_data_line_in;
    nxt_st.din_s2 = st_ff.din_s1;
    nxt_st.key_s1 = key_return_inputs;
    nxt_st.key_s2 = st_ff.key_s1;

    // ****************************************************************
    // Serial link
    // ****************************************************************
    rise = st_ff.sclk_s2 & ~st_ff.sclk_d;
    fall = ~st_ff.sclk_s2 & st_ff.sclk_d;
    byte_in = {st_ff.din_s2, st_ff.shreg[7:1]};

    if (st_ff.stb_s2) begin
      // Idle frame: clock edges have no effect, partial byte is lost
      nxt_st.lnk = LNK_CMD;
      nxt_st.bitcnt = 3'h0;
      nxt_st.shreg = 8'h00;
      nxt_st.rd_ptr = 6'h00;
      nxt_st.dio_oe = 1'b0;
    end else begin
      if (rise) begin
        nxt_st.shreg = byte_in;
        nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
        if (st_ff.lnk == LNK_READ) begin
          // Bit just taken by the host; continue across bytes
          if (st_ff.rd_ptr != 6'h3F) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + 6'h01;
          end
        end else if (st_ff.bitcnt == 3'h7) begin
          if (st_ff.lnk == LNK_CMD) begin
            nxt_st.lnk = LNK_WRITE;
            unique case (byte_in[7:6])
              `LMK_CMD_MODE: begin
                // Same mode: blanking and state untouched
                if (byte_in[1:0] != st_ff.mode) begin
                  nxt_st.mode = byte_in[1:0];
                  nxt_st.disp_on = 1'b0;
                end
              end
              `LMK_CMD_DATA: begin
                nxt_st.dset = byte_in[3:0];
                if (byte_in[1:0] == `LMK_DS_READ) begin
                  nxt_st.lnk = LNK_READ;
                  nxt_st.rd_ptr = 6'h00;
                end
              end
              `LMK_CMD_CTRL: begin
                nxt_st.dim = byte_in[2:0];
                nxt_st.disp_on = byte_in[`LMK_DC_ON_BIT];
              end
              `LMK_CMD_ADDR: begin
                nxt_st.addr = byte_in[3:0];
              end
            endcase
          end else if (st_ff.dset[1:0] == `LMK_DS_WRITE &&
                       st_ff.addr <= `LMK_ADDR_LAST) begin
            nxt_st.mem[st_ff.addr] = byte_in;
            // Saturates so the pointer never wraps back into valid space
            if (!st_ff.dset[`LMK_DS_FIXED_BIT] &&
                st_ff.addr != `LMK_ADDR_TOP) begin
              nxt_st.addr = st_ff.addr + 4'h1;
            end
          end
        end
      end
      if (fall && st_ff.lnk == LNK_READ) begin
        // Open drain: pull low for a zero, release for a one
        nxt_st.dio_oe = ~key_out_bit(st_ff.keys,
                                     st_ff.rd_ptr);
      end
    end

    // ****************************************************************
    // Display and key scan
    // ****************************************************************
    ndig = digit_count(st_ff.mode);
    last = ndig + 5'(`LMK_KEY_SOURCES - 1);
    src = st_ff.phase - ndig;
    tmp = st_ff.key_tmp;

    if (st_ff.scan_en) begin
      // Scan timebase runs from the system clock, not the host's
      if (st_ff.tick >= `LMK_TICK_LAST) begin
        nxt_st.tick = 6'h00;
        nxt_st.step = st_ff.step + 4'h1;
        if (st_ff.step == `LMK_STEP_LAST) begin
          if (st_ff.phase >= ndig) begin
            tmp[key_pos(src[3:0], 1'b0)] = st_ff.key_s2[0];
            tmp[key_pos(src[3:0], 1'b1)] = st_ff.key_s2[1];
            nxt_st.key_tmp = tmp;
          end
          // Mode may shrink mid-cycle, so wrap on reaching or passing
          if (st_ff.phase >= last) begin
            nxt_st.phase = 5'h00;
            // Whole-cycle snapshot; a read in flight may straddle two
            nxt_st.keys = tmp;
          end else begin
            nxt_st.phase = st_ff.phase + 5'h01;
          end
        end
      end else begin
        nxt_st.tick = st_ff.tick + 6'h01;
      end
    end

    // Shared pins: index 0..2 serve as grid 7..5 when the mode uses it
    for (int p = 0; p < 3; p++) begin
      grid_used[p] = (shared_digit(p) < ndig);
    end
    nxt_st.drv.seg_src = 10'h000;
    nxt_st.drv.dig_n = 4'hF;
    nxt_st.drv.shared = grid_used;
    if (st_ff.scan_en) begin
      if (st_ff.phase < ndig) begin
        if (st_ff.disp_on && pwm_lit(st_ff.step, st_ff.dim)) begin
          if (st_ff.dset[`LMK_DS_TEST_BIT]) begin
            segs = 13'h1FFF;
          end else begin
            segs = seg_map(st_ff.mem[mem_index(st_ff.phase, 1'b0)],
                           st_ff.mem[mem_index(st_ff.phase, 1'b1)]);
          end
          nxt_st.drv.seg_src = segs[9:0];
          for (int p = 0; p < 3; p++) begin
            nxt_st.drv.shared[p] = grid_used[p] ?
                                   (st_ff.phase != shared_digit(p)) :
                                   segs[10 + p];
          end
          for (int i = 0; i < 4; i++) begin
            nxt_st.drv.dig_n[i] = (st_ff.phase != 5'(i));
          end
        end
      end else begin
        // Key slot: one source high, grids idle, display state ignored
        nxt_st.drv.seg_src = 10'(10'h001 << src[3:0]);
      end
    end

    // ****************************************************************
    // APB slave: one wait-free access cycle, data staged at setup
    // ****************************************************************
    setup = psel & ~penable;
    access = psel & penable & st_ff.pready;
    nxt_st.pready = setup;
    // Unmapped offsets answer with an error and change nothing
    nxt_st.pslverr = setup & ~reg_mapped(paddr);
    // Staged at setup so the data stands through the access cycle
    if (setup) begin
      nxt_st.prdata = pwrite ? 32'h0 : reg_read(st_ff, paddr);
    end
    if (access && pwrite && paddr == `LMK_REG_CTRL) begin
      nxt_st.scan_en = pwdata[`LMK_CTRL_SCAN_BIT];
    end
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      // Strobe stages start idle-high so no false frame follows reset
      st_ff.stb_s1 <= 1'b1;
      st_ff.stb_s2 <= 1'b1;
      st_ff.lnk <= LNK_CMD;
      st_ff.mode <= `LMK_MODE_RESET;
      st_ff.disp_on <= 1'b0;
      st_ff.dim <= `LMK_DIM_RESET;
      st_ff.dset <= `LMK_DSET_RESET;
      st_ff.addr <= `LMK_ADDR_RESET;
      st_ff.scan_en <= `LMK_SCAN_EN_RESET;
      st_ff.drv.shared <= `LMK_SHARED_RESET;
      st_ff.drv.dig_n <= `LMK_DIG_N_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe = st_ff.dio_oe;
  assign segment_key_source_outputs = st_ff.drv.seg_src;
  assign shared_segment_digit_outputs = st_ff.drv.shared;
  assign digit_select_outputs_n = st_ff.drv.dig_n;

endmodule

`default_nettype wire

// *** verification/lmk_checker.sv ***
`timescale 1ns/100ps
`default_nettype none

module lmk_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_select_strobe,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic [2:0] shared_segment_digit_outputs,
  input wire logic [3:0] digit_select_outputs_n
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rdy_setup;
    psel && !penable |=> pready;
  endproperty
  a_rdy_setup: assert property (p_rdy_setup) else $error("late ready");

  property p_rdy_one;
    pready |=> !pready;
  endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");

  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error alone");

  property p_err_map;
    pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C});
  endproperty
  a_err_map: assert property (p_err_map) else $error("error map");

  property p_dio_low;
    serial_data_line_out == 1'b0;
  endproperty
  a_dio_low: assert property (p_dio_low) else $error("drove high");

  property p_dio_idle;
    frame_select_strobe [*6] |-> !serial_data_line_oe;
  endproperty
  a_dio_idle: assert property (p_dio_idle) else $error("held line");

  property p_one_grid;
    $onehot0(~digit_select_outputs_n);
  endproperty
  a_one_grid: assert property (p_one_grid) else $error("two grids");

  // First edge after release still shows the idle outputs
  property p_por;
    $rose(presetn) |-> digit_select_outputs_n == 4'hF && !pready &&
      shared_segment_digit_outputs == 3'h7 && !serial_data_line_oe;
  endproperty
  a_por: assert property (p_por) else $error("reset outputs");
endmodule

bind lmk_top lmk_checker u_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .frame_select_strobe,
  .serial_data_line_out, .serial_data_line_oe,
  .shared_segment_digit_outputs, .digit_select_outputs_n);

`default_nettype wire

// *** verification/lmk_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module lmk_host_model (
  input wire logic pclk,
  input wire logic serial_data_line,
  output logic sclk,
  output logic stb,
  output logic h_oe,
  output logic h_bit
);
  initial begin
    sclk = 1'b1;
    stb = 1'b1;
    h_oe = 1'b0;
    h_bit = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic open_frame();
    tick(4);
    stb <= 1'b0;
    tick(4);
  endtask

  // Line released on close so the pull-up shows, not the last bit
  task automatic close_frame();
    tick(4);
    stb <= 1'b1;
    h_oe <= 1'b0;
    tick(8);
  endtask

  // Data changes while clock low, device samples on the rise
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      h_oe <= 1'b1;
      h_bit <= b[i];
      tick(4);
      sclk <= 1'b1;
      tick(4);
    end
  endtask

  task automatic read_keys(output logic [39:0] k);
    open_frame();
    send_bits(8'h42, 8);
    h_oe <= 1'b0;
    tick(30);
    for (int i = 0; i < 40; i++) begin
      sclk <= 1'b0;
      tick(6);
      k[i] = serial_data_line;
      sclk <= 1'b1;
      tick(4);
    end
    close_frame();
  endtask
endmodule

`default_nettype wire

// *** verification/lmk_top_tb_top.sv ***
`timescale 1ns/100ps
`include "lmk_cfg.svh"
`default_nettype none

module lmk_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] key_return_inputs = 2'h1;
  logic [31:0] prdata;
  logic pready, pslverr, dio_out, dio_oe, sclk, stb, h_oe, h_bit, serial_data_line;
  logic [9:0] seg;
  logic [2:0] shared;
  logic [3:0] dig_n;
  logic [39:0] k;
  logic blank;
  int bad_count = 0;
  int n_compared = 0;
  int n;

  always #20 pclk = ~pclk;
  assign serial_data_line = dio_oe ? dio_out : (h_oe ? h_bit : 1'b1);

  lmk_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clock(sclk), .frame_select_strobe(stb),
    .serial_data_line_in(serial_data_line), .serial_data_line_out(dio_out),
    .serial_data_line_oe(dio_oe), .key_return_inputs(key_return_inputs),
    .segment_key_source_outputs(seg),
    .shared_segment_digit_outputs(shared), .digit_select_outputs_n(dig_n));

  lmk_host_model h (.pclk(pclk), .serial_data_line(serial_data_line), .sclk(sclk), .stb(stb),
    .h_oe(h_oe), .h_bit(h_bit));

  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic st(input int m, input int on, input int d, input int ds,
    input int a);
    rd(`LMK_REG_STATUS, {19'h0, 4'(a), 4'(ds), 3'(d), 1'(on), 2'(m)});
  endtask

  task automatic cmd(input logic [7:0] c);
    h.open_frame();
    h.send_bits(c, 8);
    h.close_frame();
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #3_800_000;
    bad_count++;
    results();
  end

  initial begin
    logic [32:0] r;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`LMK_REG_CTRL, 33'h1);
    st(3, 0, 0, 0, 0);
    apb(1'b0, 8'h10, 32'h0, r);
    chk(r[32], 1'b1);
    apb(1'b1, `LMK_REG_STATUS, 32'hFFFFFFFF, r);
    chk(r[32], 1'b0);
    cmd(8'h03);
    cmd(8'h40);
    h.open_frame();
    h.send_bits(8'hC0, 8);
    for (int i = 0; i < 14; i++) begin
      h.send_bits(i == 0 ? 8'hA5 : (i == 1 ? 8'h03 : 8'h00), 8);
    end
    h.close_frame();
    st(3, 0, 0, 0, 4'hE);
    for (int d = 0; d < 8; d++) begin
      cmd(8'(8'h88 | d));
      st(3, 1, d, 0, 4'hE);
    end
    while (dig_n[0] === 1'b0) begin
      @(posedge pclk);
    end
    n = 0;
    while (dig_n[0] !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    chk(seg, 10'h3A5);
    chk(shared, 3'h7);
    n = 0;
    while (dig_n[0] === 1'b0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(n, 14 * `LMK_OSC_TICK_CYCLES);
    cmd(8'h3C);
    st(0, 0, 7, 0, 4'hE);
    blank = 1'b1;
    repeat (14000) begin
      @(posedge pclk);
      if (dig_n !== 4'hF) blank = 1'b0;
    end
    chk(blank, 1'b1);
    cmd(8'h8F);
    cmd(8'h00);
    st(0, 1, 7, 0, 4'hE);
    for (int m = 1; m < 4; m++) begin
      cmd(8'(m));
      st(m, 0, 7, 0, 4'hE);
    end
    cmd(8'h8F);
    cmd(8'h7C);
    h.open_frame();
    h.send_bits(8'hC2, 8);
    h.send_bits(8'h11, 8);
    h.send_bits(8'h22, 8);
    h.close_frame();
    st(3, 1, 7, 4'hC, 2);
    n = 0;
    while (dig_n[0] !== 1'b0 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    chk(seg, 10'h3FF);
    cmd(8'h40);
    h.open_frame();
    h.send_bits(8'hC3, 8);
    h.send_bits(8'hC9, 8);
    h.close_frame();
    st(3, 1, 7, 0, 4);
    h.open_frame();
    h.send_bits(8'hCE, 8);
    h.send_bits(8'h55, 8);
    h.close_frame();
    st(3, 1, 7, 0, 4'hE);
    h.open_frame();
    h.send_bits(8'hC7, 4);
    h.close_frame();
    h.send_bits(8'hC5, 8);
    h.tick(8);
    st(3, 1, 7, 0, 4'hE);
    cmd(8'hC6);
    st(3, 1, 7, 0, 6);
    key_return_inputs <= 2'h2;
    h.tick(28000);
    rd(`LMK_REG_KEYS0, 33'h012121212);
    rd(`LMK_REG_KEYS1, 33'h12);
    h.read_keys(k);
    chk(k, 40'h1212121212);
    st(3, 1, 7, 2, 6);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    st(3, 0, 0, 0, 0);
    results();
  end
endmodule

`default_nettype wire
